// [rtl/ldm_misc_config_regs.v]
// ldm_misc_config_regs.v: misc config bank, apb slave, error pin and interrupts
// assumes: apb master on core_clk; fault and burn-done inputs arrive from pins
// Notes on behaviour
// RQ1 - clock-source bit 1 selects external pwm clock, 0 internal
// RQ2 - shared-duty bit 1 makes every channel use channel zero duty
// RQ3 - read-back source bit: 0 from nvm array, 1 from shadow registers
// RQ4 - programming-state bit enters or leaves nvm programming state
// RQ5 - reference fault mask bit keeps reference fault off error pin
// RQ6 - checksum fault mask bit keeps crc fault off error pin
// RQ7 - short fault mask bit keeps led short faults off error pin
// RQ8 - open fault mask bit keeps led open faults off error pin
// RQ9 - overtemp mask hides report only; shutdown still happens
// RQ10 - burn start launches burn only in programming state, self-clears
// RQ11 - single-led short start launches that diagnostic, self-clears
// RQ12 - invisible diagnostic start launches that sequence, self-clears
// RQ13 - 8-bit gate field holds password; correct value grants nvm access
// RQ14 - burn-complete flag sets when burn ends, zero before
// RQ15 - while lock bit is one, config register writes are blocked
// RQ16 - reserved bits read zero and writes to them are ignored
//
// Chosen here: register access over APB.
`timescale 1ns/1ns
`include "ldm_map.vh"
module ldm_misc_config_regs (
    input  wire        core_clk,
    input  wire        srst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [9:0]  paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    input  wire        refFaultPin,
    input  wire        crcFaultPin,
    input  wire        shortFaultPin,
    input  wire        openFaultPin,
    input  wire        overtempPin,
    input  wire        burnDonePin,
    output wire        pwmClockSourceSelect,
    output wire        sharedDutyEnable,
    output wire        readbackSourceSelect,
    output wire        nvmProgrammingState,
    output wire        nvmAccessGranted,
    output wire        burnStart,
    output wire        singleLedShortStart,
    output wire        invisibleDiagStart,
    output wire        errOut,
    output wire        errOe,
    output wire        irq
);
    // ************************************************************
    // helpers
    // ************************************************************
    function [9:0] byteAddr;
        input [7:0] idx;
        begin
            byteAddr = {idx, 2'b00};
        end
    endfunction

    function hit;
        input [9:0] a;
        input [7:0] idx;
        begin
            hit = (a == byteAddr(idx));
        end
    endfunction

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    reg [5:0] pinMeta;
    reg [5:0] pinSync;
    always @(posedge core_clk) begin
        if (srst) begin
            pinMeta <= 6'h00;
            pinSync <= 6'h00;
        end else begin
            pinMeta <= {burnDonePin, refFaultPin, crcFaultPin,
                        shortFaultPin, openFaultPin, overtempPin};
            pinSync <= pinMeta;
        end
    end
    wire burnDoneLvl = pinSync[5];

    // ************************************************************
    // apb decode
    // ************************************************************
    wire acc      = psel & penable;
    wire wrLane0  = acc & pwrite & pstrb[0];
    wire selClk   = hit(paddr, `LDM_IDX_CLKCTRL);
    wire selFault = hit(paddr, `LDM_IDX_FAULTCTRL);
    wire selGate  = hit(paddr, `LDM_IDX_GATE);
    wire selLock  = hit(paddr, `LDM_IDX_LOCKSTAT);
    wire selIst   = hit(paddr, `LDM_IDX_IRQSTAT);
    wire selImk   = hit(paddr, `LDM_IDX_IRQMASK);
    wire mapped   = selClk | selFault | selGate | selLock | selIst | selImk;

    assign pready  = 1'b1;
    // locked config writes are dropped without pslverr; they only set the blocked-write irq bit
    assign pslverr = acc & ~mapped;

    reg  [7:0] clkCtrl;
    reg  [7:0] faultCtrl;
    reg  [7:0] gate;
    reg        lockBit;
    reg        burnFlag;
    reg  [2:0] irqStat;
    reg  [2:0] irqMask;

    wire cfgOk   = ~lockBit;                                          // RQ15
    wire wrClk   = wrLane0 & selClk & cfgOk;
    wire wrFault = wrLane0 & selFault & cfgOk;
    wire wrGate  = wrLane0 & selGate & cfgOk;

    // ************************************************************
    // configuration registers
    // ************************************************************
    always @(posedge core_clk) begin
        if (srst) begin
            clkCtrl   <= `LDM_RST_CLKCTRL;
            faultCtrl <= `LDM_RST_FAULTCTRL;
            gate      <= `LDM_RST_GATE;
            lockBit   <= `LDM_RST_LOCK;
        end else begin
            if (wrClk) begin
                clkCtrl <= pwdata[7:0] & `LDM_CLK_WMASK;              // RQ16
            end
            if (wrFault) begin
                // start bits are never stored, they read back 0
                faultCtrl <= pwdata[7:0] & `LDM_FAULT_WMASK;          // RQ16
            end
            if (wrGate) begin
                gate <= pwdata[7:0];                                  // RQ13
            end
            if (wrLane0 & selLock) begin
                lockBit <= pwdata[`LDM_B_LOCK];                       // RQ15
            end
        end
    end

    assign pwmClockSourceSelect = clkCtrl[`LDM_B_CLKSRC];             // RQ1
    assign sharedDutyEnable     = clkCtrl[`LDM_B_SHARE];              // RQ2
    assign readbackSourceSelect = clkCtrl[`LDM_B_RDSRC];              // RQ3
    assign nvmProgrammingState  = clkCtrl[`LDM_B_PROGSTATE];          // RQ4
    assign nvmAccessGranted     = (gate == `LDM_GATE_CODE);           // RQ13

    // ************************************************************
    // self-clearing starts
    // ************************************************************
    wire fireBurn = wrFault & pwdata[`LDM_B_BURN] & nvmProgrammingState; // RQ10
    wire fireSs   = wrFault & pwdata[`LDM_B_SSHORT];                     // RQ11
    wire fireInv  = wrFault & pwdata[`LDM_B_INVDIAG];                    // RQ12

    ldm_start_pulse uBurn (
        .core_clk (core_clk),
        .srst     (srst),
        .fire     (fireBurn),
        .pulse    (burnStart)
    );
    ldm_start_pulse uSs (
        .core_clk (core_clk),
        .srst     (srst),
        .fire     (fireSs),
        .pulse    (singleLedShortStart)
    );
    ldm_start_pulse uInv (
        .core_clk (core_clk),
        .srst     (srst),
        .fire     (fireInv),
        .pulse    (invisibleDiagStart)
    );

    // ************************************************************
    // burn-complete flag
    // ************************************************************
    reg burnDonePrev;
    always @(posedge core_clk) begin
        if (srst) begin
            burnFlag     <= 1'b0;
            burnDonePrev <= 1'b0;
        end else begin
            burnDonePrev <= burnDoneLvl;
            if (burnDoneLvl & ~burnDonePrev) begin
                burnFlag <= 1'b1;                                     // RQ14
            end else if (burnStart) begin
                burnFlag <= 1'b0;                                     // RQ14
            end
        end
    end

    // ************************************************************
    // error pin, open drain: drive low while a report stands
    // ************************************************************
    wire errActive;
    ldm_err_combine uErr (
        .core_clk   (core_clk),
        .srst       (srst),
        .faultLevel (pinSync[4:0]),
        .faultCtrl  (faultCtrl),
        .errActive  (errActive)
    );
    assign errOut = 1'b0;
    assign errOe  = errActive;

    // ************************************************************
    // interrupts: 0 burn done, 1 error rise, 2 blocked write
    // ************************************************************
    reg  errPrev;
    wire blockedWr = wrLane0 & (selClk | selFault | selGate) & lockBit;
    wire [2:0] irqEv = {blockedWr, errActive & ~errPrev, burnDoneLvl & ~burnDonePrev};
    wire [2:0] irqClr = (wrLane0 & selIst) ? pwdata[2:0] : 3'h0;
    always @(posedge core_clk) begin
        if (srst) begin
            errPrev <= 1'b0;
            irqStat <= 3'h0;
            irqMask <= 3'h0;
        end else begin
            errPrev <= errActive;
            // a new event beats a clear in the same cycle
            irqStat <= (irqStat & ~irqClr) | irqEv;
            if (wrLane0 & selImk) begin
                irqMask <= pwdata[2:0];
            end
        end
    end
    assign irq = |(irqStat & irqMask);

    // ************************************************************
    // read data
    // ************************************************************
    always @(posedge core_clk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= 32'h0000_0000;
            if (hit(paddr, `LDM_IDX_CLKCTRL)) begin
                prdata <= {24'h000000, clkCtrl};
            end else if (hit(paddr, `LDM_IDX_FAULTCTRL)) begin
                prdata <= {24'h000000, faultCtrl};
            end else if (hit(paddr, `LDM_IDX_GATE)) begin
                prdata <= {24'h000000, gate};
            end else if (hit(paddr, `LDM_IDX_LOCKSTAT)) begin
                prdata <= {29'h0, nvmAccessGranted, burnFlag, lockBit};
            end else if (hit(paddr, `LDM_IDX_IRQSTAT)) begin
                prdata <= {29'h0, irqStat};
            end else if (hit(paddr, `LDM_IDX_IRQMASK)) begin
                prdata <= {29'h0, irqMask};
            end
        end
    end
endmodule

// [inc/ldm_map.vh]
// ldm_map.vh: register offsets, field positions, reset values and the gate code
// assumes: included by bare name from the design files; definitions only
`ifndef LDM_MAP_VH
`define LDM_MAP_VH

// ************************************************************
// register word indices; byte address is index times 4 (printed offsets are indices)
// ************************************************************
`define LDM_IDX_CLKCTRL     8'h63
`define LDM_IDX_FAULTCTRL   8'h64
`define LDM_IDX_GATE        8'h65
`define LDM_IDX_LOCKSTAT    8'h66
`define LDM_IDX_IRQSTAT     8'h67
`define LDM_IDX_IRQMASK     8'h68
`define LDM_ADDR_W          10

// ************************************************************
// field positions
// ************************************************************
`define LDM_B_CLKSRC        5
`define LDM_B_SHARE         4
`define LDM_B_RDSRC         1
`define LDM_B_PROGSTATE     0
`define LDM_B_MREF          7
`define LDM_B_MCRC          6
`define LDM_B_MSHORT        5
`define LDM_B_MOPEN         4
`define LDM_B_MTSD          3
`define LDM_B_BURN          2
`define LDM_B_SSHORT        1
`define LDM_B_INVDIAG       0
`define LDM_B_LOCK          0
`define LDM_B_BURNDONE      1
`define LDM_B_GATEOK        2

// ************************************************************
// masks and reset values
// ************************************************************
`define LDM_CLK_WMASK       8'h33
`define LDM_FAULT_WMASK     8'hf8
`define LDM_RST_CLKCTRL     8'h00
`define LDM_RST_FAULTCTRL   8'h00
`define LDM_RST_GATE        8'h00
`define LDM_RST_LOCK        1'b1
`define LDM_IRQ_W           3
// gate code is arbitrary
`define LDM_GATE_CODE       8'h5a

`endif

// [rtl/ldm_start_pulse.v]
// ldm_start_pulse.v: self-clearing start bit, one-cycle pulse per accepted write
// assumes: fire is a single-cycle strobe on core_clk
`timescale 1ns/1ns
module ldm_start_pulse (
    input  wire core_clk,
    input  wire srst,
    input  wire fire,
    output reg  pulse
);
    // bit reads back 0; the launch is a single clock wide
    always @(posedge core_clk) begin
        if (srst) begin
            pulse <= 1'b0;
        end else begin
            pulse <= fire;
        end
    end
endmodule

// [rtl/ldm_err_combine.v]
// ldm_err_combine.v: masks fault classes onto the open-drain error pin
// assumes: fault levels already synchronised to core_clk
`timescale 1ns/1ns
`include "ldm_map.vh"
module ldm_err_combine (
    input  wire       core_clk,
    input  wire       srst,
    input  wire [4:0] faultLevel,
    input  wire [7:0] faultCtrl,
    output reg        errActive
);
    // faultLevel: 4 ref, 3 crc, 2 short, 1 open, 0 overtemp
    wire refOn   = faultLevel[4] & ~faultCtrl[`LDM_B_MREF];    // RQ5
    wire crcOn   = faultLevel[3] & ~faultCtrl[`LDM_B_MCRC];    // RQ6
    wire shortOn = faultLevel[2] & ~faultCtrl[`LDM_B_MSHORT];  // RQ7
    wire openOn  = faultLevel[1] & ~faultCtrl[`LDM_B_MOPEN];   // RQ8
    // masking only hides the report; shutdown is untouched
    wire tsdOn   = faultLevel[0] & ~faultCtrl[`LDM_B_MTSD];    // RQ9

    always @(posedge core_clk) begin
        if (srst) begin
            errActive <= 1'b0;
        end else begin
            errActive <= refOn | crcOn | shortOn | openOn | tsdOn;
        end
    end
endmodule

// [verification/ldm_misc_config_regs_assertions.sv]
// ldm_misc_config_regs_assertions.sv: port-level checker for the misc config bank
// assumes: bound onto ldm_misc_config_regs; single core_clk domain
`timescale 1ns/1ns
module ldm_misc_config_regs_assertions (
    input wire        core_clk,
    input wire        srst,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [9:0]  paddr,
    input wire [31:0] pwdata,
    input wire [3:0]  pstrb,
    input wire        pready,
    input wire [31:0] prdata,
    input wire        refFaultPin,
    input wire        crcFaultPin,
    input wire        shortFaultPin,
    input wire        openFaultPin,
    input wire        overtempPin,
    input wire        pwmClockSourceSelect,
    input wire        sharedDutyEnable,
    input wire        readbackSourceSelect,
    input wire        nvmProgrammingState,
    input wire        nvmAccessGranted,
    input wire        burnStart,
    input wire        singleLedShortStart,
    input wire        invisibleDiagStart,
    input wire        errOe
);
    // shadow of lock and fault masks, since neither is visible at the ports
    reg        lockSh;
    reg  [4:0] maskSh;
    wire       wr = psel && penable && pwrite && pready && pstrb[0];
    wire [4:0] flt = {refFaultPin, crcFaultPin, shortFaultPin, openFaultPin, overtempPin};
    wire [3:0] cfg = {pwmClockSourceSelect, sharedDutyEnable, readbackSourceSelect,
                      nvmProgrammingState};
    always @(posedge core_clk) begin
        if (srst) begin
            lockSh <= 1'b1;
            maskSh <= 5'h00;
        end else begin
            if (wr && paddr == 10'h198) lockSh <= pwdata[0];
            if (wr && paddr == 10'h190 && !lockSh) maskSh <= pwdata[7:3];
        end
    end
    // ************************************************************
    // properties
    // ************************************************************
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    sequence s_cfg(a);
        wr && !lockSh && paddr == a;
    endsequence
    sequence s_pulse(sig);
        sig ##1 !sig;
    endsequence
    property p_burn;
        s_cfg(10'h190) ##0 (pwdata[2] && nvmProgrammingState) |=> s_pulse(burnStart);
    endproperty
    property p_burn_idle;
        wr && paddr == 10'h190 && !nvmProgrammingState |=> !burnStart;
    endproperty
    property p_short;
        s_cfg(10'h190) ##0 pwdata[1] |=> s_pulse(singleLedShortStart);
    endproperty
    property p_inv;
        s_cfg(10'h190) ##0 pwdata[0] |=> s_pulse(invisibleDiagStart);
    endproperty
    property p_ctrl;
        s_cfg(10'h18c) |=> cfg == {$past(pwdata[5:4]), $past(pwdata[1:0])};
    endproperty
    property p_lock;
        wr && lockSh && paddr == 10'h18c |=> $stable(cfg);
    endproperty
    property p_gate;
        s_cfg(10'h194) |=> nvmAccessGranted == ($past(pwdata[7:0]) == 8'h5a);
    endproperty
    property p_err_on;
        ((flt & ~maskSh) != 5'h00) [*4] |-> errOe;
    endproperty
    property p_err_off;
        ((flt & ~maskSh) == 5'h00) [*4] |-> !errOe;
    endproperty
    property p_resv;
        psel && penable && !pwrite |-> prdata[31:8] == 24'h000000;
    endproperty
    a_burn: assert property (p_burn) else $error("burn start pulse wrong");
    a_burn_idle: assert property (p_burn_idle) else $error("burn outside prog");
    a_short: assert property (p_short) else $error("short start pulse wrong");
    a_inv: assert property (p_inv) else $error("diag start pulse wrong");
    a_ctrl: assert property (p_ctrl) else $error("ctrl outputs wrong");
    a_lock: assert property (p_lock) else $error("locked write changed ctrl");
    a_gate: assert property (p_gate) else $error("access grant wrong");
    a_err_on: assert property (p_err_on) else $error("fault not reported");
    a_err_off: assert property (p_err_off) else $error("masked fault shown");
    a_resv: assert property (p_resv) else $error("upper read bits set");
endmodule

bind ldm_misc_config_regs ldm_misc_config_regs_assertions chk (
    .core_clk             (core_clk),
    .srst                 (srst),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .pstrb                (pstrb),
    .pready               (pready),
    .prdata               (prdata),
    .refFaultPin          (refFaultPin),
    .crcFaultPin          (crcFaultPin),
    .shortFaultPin        (shortFaultPin),
    .openFaultPin         (openFaultPin),
    .overtempPin          (overtempPin),
    .pwmClockSourceSelect (pwmClockSourceSelect),
    .sharedDutyEnable     (sharedDutyEnable),
    .readbackSourceSelect (readbackSourceSelect),
    .nvmProgrammingState  (nvmProgrammingState),
    .nvmAccessGranted     (nvmAccessGranted),
    .burnStart            (burnStart),
    .singleLedShortStart  (singleLedShortStart),
    .invisibleDiagStart   (invisibleDiagStart),
    .errOe                (errOe)
);

// [verification/ldm_misc_config_regs_test.sv]
// ldm_misc_config_regs_test.sv: self-checking bench with a behavioural register model
// assumes: ldm_map.vh on the include path; bench is apb master and drives fault pins
`timescale 1ns/1ns
`include "ldm_map.vh"
module ldm_misc_config_regs_test;
    localparam [9:0] A_CLK = {`LDM_IDX_CLKCTRL, 2'b00}, A_FLT = {`LDM_IDX_FAULTCTRL, 2'b00},
                     A_GATE = {`LDM_IDX_GATE, 2'b00}, A_LOCK = {`LDM_IDX_LOCKSTAT, 2'b00},
                     A_STAT = {`LDM_IDX_IRQSTAT, 2'b00}, A_MASK = {`LDM_IDX_IRQMASK, 2'b00};
    reg         core_clk, srst, psel, penable, pwrite, burnDonePin, err, mLock, mFlag, lastErr;
    reg  [9:0]  paddr;
    reg  [31:0] pwdata, rd;
    reg  [3:0]  pstrb;
    reg  [4:0]  flt;
    reg  [7:0]  mClk, mFault, mGate, mStat, mMask;
    wire        pready, pslverr, errOut, errOe, irq, burnStart, ssStart, invStart, granted;
    wire [3:0]  cfgOut;
    wire [31:0] prdata;
    integer     fails, samplesChecked, nBurn, nSs, nInv, eBurn, eSs, eInv, i, j;
    ldm_misc_config_regs uut (
        .core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .refFaultPin(flt[4]), .crcFaultPin(flt[3]),
        .shortFaultPin(flt[2]), .openFaultPin(flt[1]), .overtempPin(flt[0]),
        .burnDonePin(burnDonePin), .pwmClockSourceSelect(cfgOut[3]),
        .sharedDutyEnable(cfgOut[2]), .readbackSourceSelect(cfgOut[1]),
        .nvmProgrammingState(cfgOut[0]), .nvmAccessGranted(granted), .burnStart(burnStart),
        .singleLedShortStart(ssStart), .invisibleDiagStart(invStart), .errOut(errOut),
        .errOe(errOe), .irq(irq));
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        nBurn = nBurn + (burnStart === 1'b1);
        nSs = nSs + (ssStart === 1'b1);
        nInv = nInv + (invStart === 1'b1);
    end
    // ************************************************************
    // tasks
    // ************************************************************
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked = samplesChecked + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("[ERR] %0s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
        integer n;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n = n + 1;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) fails = fails + 1;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [9:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'($urandom), d});
        // locked config writes only raise the blocked-write event
        if (pstrb[0] && mLock && (a == A_CLK || a == A_FLT || a == A_GATE)) mStat[2] = 1'b1;
        else if (pstrb[0]) case (a)
            A_CLK: mClk = d & `LDM_CLK_WMASK;
            A_GATE: mGate = d;
            A_LOCK: mLock = d[0];
            A_STAT: mStat = mStat & ~d;
            A_MASK: mMask = d & 8'h07;
            A_FLT: begin
                mFault = d & `LDM_FAULT_WMASK;
                eSs = eSs + d[1];
                eInv = eInv + d[0];
                if (d[2] && mClk[0]) eBurn = eBurn + 1;
                if (d[2] && mClk[0]) mFlag = 1'b0;
            end
            default: ;
        endcase
    endtask
    task rdchk(input logic [9:0] a);
        logic [31:0] e;
        case (a)
            A_CLK: e = mClk;
            A_FLT: e = mFault;
            A_GATE: e = mGate;
            A_LOCK: e = {mGate == `LDM_GATE_CODE, mFlag, mLock};
            A_STAT: e = mStat;
            A_MASK: e = mMask;
            default: e = 0;
        endcase
        apb(1'b0, a, $urandom);
        chk("prdata", rd, e);
        chk("pslverr", err, a > A_MASK);
    endtask
    task outs;
        // registered and irq outputs update in the nba region of the access edge
        @(negedge core_clk);
        chk("cfg", cfgOut, {mClk[5:4], mClk[1:0]});
        chk("granted", granted, mGate == `LDM_GATE_CODE);
        chk("irq", irq, |(mStat & mMask));
    endtask
    task endOfTest;
        if (fails == 0 && samplesChecked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #100000;
        fails = fails + 1;
        endOfTest;
    end
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        void'($urandom(32'h70af));
        {fails, samplesChecked, nBurn, nSs, nInv, eBurn, eSs, eInv} = 0;
        {psel, penable, pwrite, paddr, pwdata, flt, burnDonePin, lastErr} = 0;
        {mClk, mFault, mGate, mStat, mMask, mFlag} = 0;
        pstrb = 4'hf;
        mLock = 1'b1;
        srst = 1'b1;
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        for (i = 0; i < 8; i = i + 1) rdchk(A_CLK + 10'(4 * i));
        wr(A_MASK, 8'h07);
        wr(A_CLK, 8'hff);
        outs;
        wr(A_STAT, 8'h04);
        wr(A_LOCK, 8'h00);
        for (i = 0; i < 6; i = i + 1) begin
            wr(A_CLK, 8'($urandom));
            wr(A_GATE, 8'($urandom));
            outs;
            rdchk(A_CLK);
            rdchk(A_GATE);
        end
        wr(A_GATE, `LDM_GATE_CODE);
        pstrb <= 4'h0;
        wr(A_GATE, 8'h11);
        pstrb <= 4'hf;
        outs;
        wr(A_CLK, 8'h00);
        wr(A_FLT, 8'h07);
        rdchk(A_FLT);
        wr(A_FLT, 8'h03);
        wr(A_CLK, 8'h01);
        wr(A_FLT, 8'h04);
        burnDonePin <= 1'b1;
        repeat (6) @(posedge core_clk);
        mFlag = 1'b1;
        mStat[0] = 1'b1;
        rdchk(A_LOCK);
        burnDonePin <= 1'b0;
        outs;
        wr(A_FLT, 8'h04);
        rdchk(A_LOCK);
        repeat (2) @(posedge core_clk);
        chk("burns", nBurn, eBurn);
        chk("shorts", nSs, eSs);
        chk("diags", nInv, eInv);
        for (i = 0; i < 5; i = i + 1) for (j = 0; j < 2; j = j + 1) begin
            wr(A_FLT, 8'(j << (i + 3)));
            flt <= 5'(1 << i);
            repeat (6) @(posedge core_clk);
            chk("errOe", {errOut, errOe}, {1'b0, j == 0});
            if (j == 0 && !lastErr) mStat[1] = 1'b1;
            flt <= 5'h00;
            repeat (6) @(posedge core_clk);
        end
        rdchk(A_STAT);
        outs;
        wr(A_STAT, 8'hff);
        outs;
        endOfTest;
    end
endmodule
